// ===== hdl/ddsc_core.sv
// Purpose: Serial command port and double-buffered registers of a dual DAC
// Assumes: clk_i much faster than the serial clock; all pins synchronised
// Notes: Serial clock edges found by sampling; readback pin is three-state
// What this block does
// RULE1 - Sample data on rising serial clock while selected
// RULE2 - Frame: command, address, then 24 data bits
// RULE3 - Code writes: 18 bits first, 6 ignored
// RULE4 - Span in low nibble of second byte
// RULE5 - Writes change only pending registers
// RULE6 - Update copies pending code and span together
// RULE7 - Manual span mode takes span from pins
// RULE8 - Readback pin low until data field
// RULE9 - Readback pin released while deselected
// RULE10 - Readback bits launched on falling clock edges
// RULE11 - Readback layout: code first, span second byte
// RULE12 - Read commands answer in same frame
// RULE13 - Other commands return previous pointer's register
// RULE14 - Each command sets next readback pointer
// RULE15 - Write and update command decode
// RULE16 - Read command decode
// RULE17 - Clear or power-up points at channel A span
// RULE18 - Address decode; both-channels reads channel A
// RULE19 - Span codes decoded ignoring top bit
// RULE20 - Load-all pin updates when deselected only
// RULE21 - Active span readback reports span in force
// RULE22 - Power-up clears every code and span register to zero
// RULE23 - Clear pin zeroes active registers only
// RULE24 - Clear during a frame aborts it
// RULE25 - Reset flag low until valid update
// RULE26 - Bits shifted most significant first
// RULE27 - Execute on select rising after 32 bits
// RULE28 - Reserved codes change nothing
`timescale 1ns/1ps
module ddsc_core
  import ddsc_pkg::*;
#(
  parameter int CODE_WIDTH = ddsc_pkg::CODE_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial port pins
  input wire logic select_and_load_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_data_in_i,
  output logic readback_out_o,
  output logic readback_out_oe_o,
  // Control pins
  input wire logic async_load_all_n_i,
  input wire logic async_clear_n_i,
  input wire logic manual_span_i,
  input wire logic span_bit0_i,
  input wire logic span_bit1_i,
  input wire logic span_bit2_i,
  // Status and DAC values
  output logic reset_flag_n_o,
  output logic [ddsc_pkg::CODE_W-1:0] active_code_a_o,
  output logic [ddsc_pkg::CODE_W-1:0] active_code_b_o,
  output logic [ddsc_pkg::SPAN_W-1:0] active_span_a_o,
  output logic [ddsc_pkg::SPAN_W-1:0] active_span_b_o,
  output logic [2:0] span_range_a_o,
  output logic [2:0] span_range_b_o
);
  import ddsc_pkg::*;

  initial begin
    if (CODE_WIDTH != CODE_W) $error("CODE_WIDTH must match the frame layout");
  end

  typedef struct packed {
    logic [1:0] sck_d;
    logic sel_d;
    logic async_load_all_n_d;
    logic [5:0] bit_cnt;
    logic [FRAME_BITS-1:0] shreg;
    logic [DATA_BITS-1:0] rb_sh;
    logic rb_drive;
    logic [1:0] ptr_kind;
    logic ptr_ch;
    logic aborted;
    logic [1:0][CODE_W-1:0] pcode;
    logic [1:0][SPAN_W-1:0] pspan;
    logic [1:0][CODE_W-1:0] acode;
    logic [1:0][SPAN_W-1:0] aspan;
    logic reset_flag_n_n;
    logic rb_out;
  } ddsc_state_t;

  ddsc_state_t st_reg;
  ddsc_state_t st_next;

  logic sel_n_s;
  logic sck_s;
  logic sdi_s;
  logic async_load_all_n_n_s;
  logic clr_n_s;
  logic mspan_s;
  logic [2:0] span_pins_s;

  // Reset levels match idle pins, so no false serial clock edge follows reset
  ddsc_sync2 #(
    .WIDTH(9),
    .INIT(9'h130)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({select_and_load_n_i, serial_clk_i, serial_data_in_i,
              async_load_all_n_i, async_clear_n_i, manual_span_i,
              span_bit2_i, span_bit1_i, span_bit0_i}),
    .sync_o({sel_n_s, sck_s, sdi_s, async_load_all_n_n_s, clr_n_s, mspan_s, span_pins_s})
  );

  // Span actually in force per channel
  function automatic logic [SPAN_W-1:0] span_in_force(input logic [SPAN_W-1:0] reg_span,
                                                      input logic mspan,
                                                      input logic [2:0] pins);
    span_in_force = mspan ? {1'b0, pins} : reg_span; // [RULE7] [RULE21]
  endfunction

  // Pick readback word for a kind/channel pair
  function automatic logic [DATA_BITS-1:0] rb_word(input ddsc_state_t s,
                                                   input logic [1:0] kind,
                                                   input logic ch,
                                                   input logic mspan,
                                                   input logic [2:0] pins);
    logic [DATA_BITS-1:0] w;
    w = '0;
    unique case (kind)
      PTR_PSPAN: w[SPAN_LSB +: SPAN_W] = s.pspan[ch]; // [RULE11]
      PTR_PCODE: w[CODE_LSB +: CODE_W] = s.pcode[ch]; // [RULE11]
      PTR_ASPAN: w[SPAN_LSB +: SPAN_W] = span_in_force(s.aspan[ch], mspan, pins); // [RULE21]
      PTR_ACODE: w[CODE_LSB +: CODE_W] = s.acode[ch];
    endcase
    rb_word = w;
  endfunction

  logic sck_rise;
  logic sck_fall;
  logic sel_rise;
  logic sel_fall;
  logic [3:0] cmd_f;
  logic [2:0] addr_f;
  logic [3:0] hdr_cmd;
  logic [2:0] hdr_addr;
  logic addr_ok;
  logic hdr_addr_ok;
  logic [1:0] ch_mask;
  logic rd_ch;
  logic [DATA_BITS-1:0] data_f;
  logic do_wspan;
  logic do_wcode;
  logic upd_n;
  logic upd_all;
  logic [1:0] upd_mask;
  logic cmd_ok;

  always_comb begin
    sck_rise = st_reg.sck_d[1] == 1'b0 && st_reg.sck_d[0] == 1'b1;
    sck_fall = st_reg.sck_d[1] == 1'b1 && st_reg.sck_d[0] == 1'b0;
    sel_rise = st_reg.sel_d == 1'b0 && sel_n_s == 1'b1;
    sel_fall = st_reg.sel_d == 1'b1 && sel_n_s == 1'b0;
    // Frame fields, MSB first
    cmd_f = st_reg.shreg[FRAME_BITS-1 -: 4]; // [RULE2] [RULE26]
    addr_f = st_reg.shreg[FRAME_BITS-5 -: 3]; // [RULE18]
    data_f = st_reg.shreg[DATA_BITS-1:0];
    // Header as it stands once 8 bits are in
    hdr_cmd = st_reg.shreg[HDR_BITS-1 -: 4];
    hdr_addr = st_reg.shreg[HDR_BITS-5 -: 3];
    addr_ok = addr_f == ADDR_CH_A || addr_f == ADDR_CH_B || addr_f == ADDR_ALL; // [RULE18]
    hdr_addr_ok = hdr_addr == ADDR_CH_A || hdr_addr == ADDR_CH_B || hdr_addr == ADDR_ALL;
    ch_mask = (addr_f == ADDR_ALL) ? 2'h3 : (addr_f == ADDR_CH_B) ? 2'h2 : 2'h1;
    rd_ch = hdr_addr == ADDR_CH_B; // [RULE18]
    do_wspan = 1'b0;
    do_wcode = 1'b0;
    upd_n = 1'b0;
    upd_all = 1'b0;
    cmd_ok = 1'b1;
    unique case (cmd_f) // [RULE15]
      CMD_WR_SPAN: do_wspan = 1'b1;
      CMD_WR_CODE: do_wcode = 1'b1;
      CMD_UPD_N: upd_n = 1'b1;
      CMD_UPD_ALL: upd_all = 1'b1;
      CMD_WS_UPD_N: begin
        do_wspan = 1'b1;
        upd_n = 1'b1;
      end
      CMD_WC_UPD_N: begin
        do_wcode = 1'b1;
        upd_n = 1'b1;
      end
      CMD_WS_UPD_ALL: begin
        do_wspan = 1'b1;
        upd_all = 1'b1;
      end
      CMD_WC_UPD_ALL: begin
        do_wcode = 1'b1;
        upd_all = 1'b1;
      end
      CMD_RD_PSPAN, CMD_RD_PCODE, CMD_RD_ASPAN, CMD_RD_ACODE, CMD_NOP: ;
      default: cmd_ok = 1'b0; // [RULE28]
    endcase
    upd_mask = upd_all ? 2'h3 : (upd_n ? ch_mask : 2'h0);
  end

  logic frame_done;
  assign frame_done = sel_rise && st_reg.bit_cnt == BIT_CNT_FULL && !st_reg.aborted; // [RULE27]

  always_comb begin
    st_next = st_reg;
    st_next.sck_d = {st_reg.sck_d[0], sck_s};
    st_next.sel_d = sel_n_s;
    st_next.async_load_all_n_d = async_load_all_n_n_s;

    if (sel_fall) begin
      st_next.bit_cnt = '0;
      st_next.aborted = 1'b0;
      st_next.rb_drive = 1'b0;
      st_next.rb_out = 1'b0; // [RULE8]
    end else if (!sel_n_s && !st_reg.sel_d) begin
      if (sck_rise && st_reg.bit_cnt != BIT_CNT_FULL) begin
        st_next.shreg = {st_reg.shreg[FRAME_BITS-2:0], sdi_s}; // [RULE1] [RULE26]
        st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
      end
      // Falling edge after the header launches the data field
      if (sck_fall && st_reg.bit_cnt == BIT_CNT_HDR) begin // [RULE10]
        // Read codes carry the kind in their low bits with the upper one inverted
        if (hdr_addr_ok && hdr_cmd >= CMD_RD_PSPAN && hdr_cmd <= CMD_RD_ACODE) begin
          st_next.rb_sh = rb_word(st_reg, {~hdr_cmd[1], hdr_cmd[0]}, rd_ch, mspan_s,
                                  span_pins_s); // [RULE12] [RULE16]
        end else begin
          st_next.rb_sh = rb_word(st_reg, st_reg.ptr_kind, st_reg.ptr_ch, mspan_s,
                                  span_pins_s); // [RULE13]
        end
        st_next.rb_drive = 1'b1;
        st_next.rb_out = st_next.rb_sh[DATA_BITS-1];
      end else if (sck_fall && st_reg.rb_drive && st_reg.bit_cnt > BIT_CNT_HDR) begin
        st_next.rb_sh = {st_reg.rb_sh[DATA_BITS-2:0], 1'b0}; // [RULE10] [RULE26]
        st_next.rb_out = st_reg.rb_sh[DATA_BITS-2];
      end
    end

    if (frame_done && cmd_ok && addr_ok) begin
      for (int c = 0; c < 2; c++) begin
        if (ch_mask[c] && do_wcode) begin
          st_next.pcode[c] = data_f[CODE_LSB +: CODE_W]; // [RULE3] [RULE5]
        end
        if (ch_mask[c] && do_wspan) begin
          st_next.pspan[c] = data_f[SPAN_LSB +: SPAN_W]; // [RULE4] [RULE5]
        end
      end
      for (int c = 0; c < 2; c++) begin
        if (upd_mask[c]) begin
          st_next.acode[c] = st_next.pcode[c]; // [RULE6]
          if (!mspan_s) begin
            st_next.aspan[c] = st_next.pspan[c]; // [RULE6] [RULE7]
          end else begin
            st_next.aspan[c] = {1'b0, span_pins_s}; // [RULE7]
          end
        end
      end
      if (upd_n || upd_all) begin
        st_next.reset_flag_n_n = 1'b1; // [RULE25]
      end
      st_next.ptr_ch = addr_f == ADDR_CH_B; // [RULE18]
      unique case (cmd_f) // [RULE14]
        CMD_WR_SPAN: st_next.ptr_kind = PTR_PSPAN;
        CMD_WR_CODE: st_next.ptr_kind = PTR_PCODE;
        CMD_UPD_N, CMD_WS_UPD_N, CMD_WS_UPD_ALL: st_next.ptr_kind = PTR_ASPAN;
        CMD_RD_PSPAN, CMD_RD_PCODE, CMD_RD_ASPAN, CMD_RD_ACODE: begin
          st_next.ptr_kind = {~cmd_f[1], cmd_f[0]}; // [RULE16]
        end
        default: st_next.ptr_kind = PTR_ACODE;
      endcase
    end

    // Load-all pin: falling edge while deselected; locked out during a frame
    if (st_reg.async_load_all_n_d && !async_load_all_n_n_s && sel_n_s && st_reg.sel_d) begin // [RULE20]
      for (int c = 0; c < 2; c++) begin
        st_next.acode[c] = st_reg.pcode[c];
        st_next.aspan[c] = mspan_s ? {1'b0, span_pins_s} : st_reg.pspan[c]; // [RULE7]
      end
      st_next.reset_flag_n_n = 1'b1; // [RULE25]
    end

    // Clear wins over everything; pending registers kept
    if (!clr_n_s) begin
      st_next.acode = '0; // [RULE23]
      st_next.aspan = '0; // [RULE23]
      st_next.reset_flag_n_n = 1'b0; // [RULE25]
      st_next.ptr_kind = PTR_ASPAN; // [RULE17]
      st_next.ptr_ch = 1'b0; // [RULE17]
      if (!sel_n_s) begin
        st_next.aborted = 1'b1; // [RULE24]
      end
    end
  end

  // Power-up: code and span registers zero, flag asserted, pointer on channel A span
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0; // [RULE22]
      st_reg.sck_d <= 2'h0;
      st_reg.sel_d <= 1'b1;
      st_reg.async_load_all_n_d <= 1'b1;
      st_reg.ptr_kind <= PTR_ASPAN; // [RULE17]
      st_reg.reset_flag_n_n <= 1'b0; // [RULE25]
    end else begin
      st_reg <= st_next;
    end
  end

  assign readback_out_o = st_reg.rb_out;
  // Released as soon as the select line rises, seen through the synchroniser
  assign readback_out_oe_o = !sel_n_s && !st_reg.sel_d; // [RULE9]
  assign reset_flag_n_o = st_reg.reset_flag_n_n;
  assign active_code_a_o = st_reg.acode[0];
  assign active_code_b_o = st_reg.acode[1];
  assign active_span_a_o = st_reg.aspan[0];
  assign active_span_b_o = st_reg.aspan[1];
  // Range index ignores top span bit; codes above 3'h5 are reserved
  assign span_range_a_o = st_reg.aspan[0][2:0]; // [RULE19]
  assign span_range_b_o = st_reg.aspan[1][2:0]; // [RULE19]
endmodule

// ===== hdl/ddsc_pkg.sv
// Purpose: Shared constants for the dual DAC serial control block
// Assumes: Frame of 8 header bits then 24 data bits, MSB first
// Notes: Command, address and readback pointer encodings live here
package ddsc_pkg;
  localparam int CODE_W = 18;
  localparam int SPAN_W = 4;
  localparam int FRAME_BITS = 32;
  localparam int HDR_BITS = 8;
  localparam int DATA_BITS = 24;
  localparam logic [5:0] BIT_CNT_HDR = 6'h08;
  localparam logic [5:0] BIT_CNT_FULL = 6'h20;
  // Span sits in low nibble of second data byte
  localparam int SPAN_LSB = 8;
  localparam int CODE_LSB = 6;

  localparam logic [3:0] CMD_WR_SPAN = 4'h2;
  localparam logic [3:0] CMD_WR_CODE = 4'h3;
  localparam logic [3:0] CMD_UPD_N = 4'h4;
  localparam logic [3:0] CMD_UPD_ALL = 4'h5;
  localparam logic [3:0] CMD_WS_UPD_N = 4'h6;
  localparam logic [3:0] CMD_WC_UPD_N = 4'h7;
  localparam logic [3:0] CMD_WS_UPD_ALL = 4'h8;
  localparam logic [3:0] CMD_WC_UPD_ALL = 4'h9;
  localparam logic [3:0] CMD_RD_PSPAN = 4'ha;
  localparam logic [3:0] CMD_RD_PCODE = 4'hb;
  localparam logic [3:0] CMD_RD_ASPAN = 4'hc;
  localparam logic [3:0] CMD_RD_ACODE = 4'hd;
  localparam logic [3:0] CMD_NOP = 4'hf;

  localparam logic [2:0] ADDR_CH_A = 3'h0;
  localparam logic [2:0] ADDR_CH_B = 3'h1;
  localparam logic [2:0] ADDR_ALL = 3'h7;

  // Readback pointer selects register kind plus channel
  localparam logic [1:0] PTR_PSPAN = 2'h0;
  localparam logic [1:0] PTR_PCODE = 2'h1;
  localparam logic [1:0] PTR_ASPAN = 2'h2;
  localparam logic [1:0] PTR_ACODE = 2'h3;
endpackage

// ===== hdl/ddsc_sync2.sv
// Purpose: Two flip-flop synchroniser for asynchronous pins
// Assumes: Inputs arrive from outside the clk_i domain
// Notes: First stage is read by the second stage only
`timescale 1ns/1ps
module ddsc_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ddsc_sync_t;
  ddsc_sync_t st_reg;
  ddsc_sync_t st_next;

  initial begin
    if (WIDTH < 1) $error("WIDTH must be positive");
  end

  always_comb begin
    st_next.s1 = async_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= {INIT, INIT};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.s2;
endmodule

// ===== bench/ddsc_core_properties.sv
// Purpose: Port-level checks for the dual DAC serial control block
// Assumes: One clk_i domain, clk_i far faster than the serial clock
// Notes: Pin synchronisers give a few cycles of lag, allowed for below
`timescale 1ns/1ps
module ddsc_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic select_and_load_n_i,
  input wire logic async_load_all_n_i,
  input wire logic async_clear_n_i,
  input wire logic manual_span_i,
  input wire logic span_bit0_i,
  input wire logic span_bit1_i,
  input wire logic span_bit2_i,
  // Outputs watched
  input wire logic readback_out_o,
  input wire logic readback_out_oe_o,
  input wire logic reset_flag_n_o,
  input wire logic [ddsc_pkg::CODE_W-1:0] active_code_a_o,
  input wire logic [ddsc_pkg::CODE_W-1:0] active_code_b_o,
  input wire logic [ddsc_pkg::SPAN_W-1:0] active_span_a_o,
  input wire logic [2:0] span_range_a_o
);
  import ddsc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_oe_off;
    select_and_load_n_i [*4] |=> !readback_out_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("readback driven while idle");
  property p_oe_on;
    !select_and_load_n_i [*4] |=> readback_out_oe_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("readback not driven in frame");
  property p_hdr_low;
    $rose(readback_out_oe_o) |-> !readback_out_o [*8];
  endproperty
  a_hdr_low: assert property (p_hdr_low) else $error("readback not low at start");
  property p_clr_zero;
    !async_clear_n_i [*4] |=> active_code_a_o == '0 && active_code_b_o == '0
      && active_span_a_o == '0;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear left active values");
  property p_clr_flag;
    !async_clear_n_i [*4] |=> !reset_flag_n_o;
  endproperty
  a_clr_flag: assert property (p_clr_flag) else $error("flag high during clear");
  property p_range;
    span_range_a_o == active_span_a_o[2:0];
  endproperty
  a_range: assert property (p_range) else $error("range index differs from span");
  property p_manual;
    manual_span_i && $changed(active_span_a_o) |-> active_span_a_o == '0
      || active_span_a_o == {1'b0, span_bit2_i, span_bit1_i, span_bit0_i};
  endproperty
  a_manual: assert property (p_manual) else $error("span not from pins");
  property p_frame_stable;
    (!select_and_load_n_i && async_clear_n_i) [*8] |=> $stable(active_code_a_o)
      && $stable(active_span_a_o);
  endproperty
  a_frame_stable: assert property (p_frame_stable) else $error("active moved in frame");
  property p_flag_rise;
    $rose(reset_flag_n_o) |-> $past(select_and_load_n_i, 2) && async_clear_n_i;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag rose without update");
  cover property (manual_span_i && $changed(active_span_a_o));
  cover property ($rose(reset_flag_n_o));
  cover property ($fell(async_load_all_n_i) && select_and_load_n_i);
endmodule
bind ddsc_core ddsc_chk u_chk (.clk_i, .rst_i, .select_and_load_n_i, .async_load_all_n_i,
  .async_clear_n_i, .manual_span_i, .span_bit0_i, .span_bit1_i, .span_bit2_i,
  .readback_out_o, .readback_out_oe_o, .reset_flag_n_o, .active_code_a_o, .active_code_b_o,
  .active_span_a_o, .span_range_a_o);

// ===== bench/ddsc_host_model.sv
// Purpose: Serial host that sends 32-bit frames and collects readback
// Assumes: Serial clock 64 ns, low 5 and high 3 system cycles
// Notes: Low phase is the longer one so readback has settled at sampling
`timescale 1ns/1ps
module ddsc_host_model (
  // Clock
  input wire logic clk_i,
  // Serial pins
  output logic sel_n_o,
  output logic sck_o,
  output logic sdi_o,
  input wire logic rb_i,
  input wire logic rb_oe_i
);
  initial begin
    sel_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // Clock idles low between frames; data inverted once released
  task automatic frame(input logic [31:0] word, output logic [23:0] rb, output int hdr_bad);
    hdr_bad = 0;
    rb = '0;
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int k = 0; k < 32; k++) begin
      sdi_o <= word[31-k];
      repeat (5) @(posedge clk_i);
      if (k < 8) begin
        if (rb_i !== 1'b0 || rb_oe_i !== 1'b1) hdr_bad++;
      end else begin
        rb = {rb[22:0], rb_i};
      end
      sck_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
    sel_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the dual DAC serial control block
// Assumes: Host model drives the serial pins, bench drives the rest
// Notes: Each scenario up to t_manual_and_load leans on the pointer left by the one before; t_clear repoints it by clearing
`timescale 1ns/1ps
module tb_top;
  import ddsc_pkg::*;
  logic clk, rst, sel_n, sck, serial_data_in, ldall_n, clr_n, mspan, rb, rb_oe, flag_n;
  logic [2:0] pins, rng_a, rng_b;
  logic [CODE_W-1:0] code_a, code_b;
  logic [SPAN_W-1:0] span_a, span_b;
  logic [23:0] rbw;
  int hb;
  int err_total = 0;
  int checks_done = 0;
  localparam logic [17:0] C1 = 18'h2a5c3;
  localparam logic [17:0] C2 = 18'h3ffff;
  localparam logic [17:0] C3 = 18'h00001;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ddsc_core dut (.clk_i(clk), .rst_i(rst), .select_and_load_n_i(sel_n), .serial_clk_i(sck),
    .serial_data_in_i(serial_data_in), .readback_out_o(rb), .readback_out_oe_o(rb_oe),
    .async_load_all_n_i(ldall_n), .async_clear_n_i(clr_n), .manual_span_i(mspan),
    .span_bit0_i(pins[0]), .span_bit1_i(pins[1]), .span_bit2_i(pins[2]),
    .reset_flag_n_o(flag_n), .active_code_a_o(code_a), .active_code_b_o(code_b),
    .active_span_a_o(span_a), .active_span_b_o(span_b), .span_range_a_o(rng_a),
    .span_range_b_o(rng_b));
  ddsc_host_model host (.clk_i(clk), .sel_n_o(sel_n), .sck_o(sck), .sdi_o(serial_data_in),
    .rb_i(rb), .rb_oe_i(rb_oe));
  function automatic logic [23:0] cw(input logic [17:0] c);
    return {c, 6'h00};
  endfunction
  function automatic logic [23:0] sw(input logic [3:0] s);
    return {12'h000, s, 8'h00};
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] hdr, input logic [23:0] d, input logic [23:0] exp);
    host.frame({hdr, d}, rbw, hb);
    chk(24'(hb), 24'h0, "header readback");
    chk(rbw, exp, "readback word");
  endtask
  task automatic t_reset;
    chk(24'(code_a), 24'h0, "reset code a");
    chk(24'(code_b), 24'h0, "reset code b");
    chk(24'({span_a, span_b}), 24'h0, "reset spans");
    chk(24'({flag_n, rb_oe}), 24'h0, "flag and enable");
  endtask
  task automatic t_write_update;
    xfer(8'h20, sw(4'h3), 24'h0);
    xfer(8'h30, cw(C1), sw(4'h3));
    chk(24'(code_a), 24'h0, "code before update");
    xfer(8'h40, 24'h0, cw(C1));
    chk(24'(code_a), 24'(C1), "code after update");
    chk(24'({span_a, rng_a}), 24'({4'h3, 3'h3}), "span after update");
    chk(24'(flag_n), 24'h1, "flag after update");
    xfer(8'hde, 24'h0, cw(C1));
  endtask
  task automatic t_all_and_reserved;
    xfer(8'h82, sw(4'h5), cw(C1));
    chk(24'({span_b, rng_b, span_a}), 24'({4'h5, 3'h5, 4'h3}), "span update all");
    xfer(8'h72, cw(C2), sw(4'h5));
    chk(24'(code_b), 24'(C2), "code update b");
    xfer(8'hf0, 24'h0, cw(C2));
    xfer(8'hb2, 24'h0, cw(C2));
    xfer(8'h00, sw(4'h7), cw(C2));
    xfer(8'h24, sw(4'h7), cw(C2));
    xfer(8'ha0, 24'h0, sw(4'h3));
  endtask
  task automatic t_manual_and_load;
    @(posedge clk);
    mspan <= 1'b1;
    pins <= 3'h4;
    xfer(8'h5e, 24'h0, sw(4'h3));
    chk(24'({span_a, span_b}), 24'h44, "manual spans");
    xfer(8'hc2, 24'h0, sw(4'h4));
    xfer(8'h60, sw(4'h2), sw(4'h4));
    chk(24'(span_a), 24'h4, "manual kept");
    xfer(8'h30, cw(C3), sw(4'h4));
    xfer(8'hb0, 24'h0, cw(C3));
    // Load-all pulse inside a frame must be locked out
    fork
      xfer(8'hd0, 24'h0, cw(C1));
      begin
        repeat (40) @(posedge clk);
        ldall_n <= 1'b0;
        repeat (6) @(posedge clk);
        ldall_n <= 1'b1;
      end
    join
    chk(24'(code_a), 24'(C1), "load all locked out");
    ldall_n <= 1'b0;
    repeat (6) @(posedge clk);
    ldall_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(24'(code_a), 24'(C3), "load all");
    mspan <= 1'b0;
  endtask
  task automatic t_clear;
    @(posedge clk);
    clr_n <= 1'b0;
    repeat (6) @(posedge clk);
    clr_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(24'({code_a, span_a, flag_n}), 24'h0, "cleared");
    xfer(8'hf0, 24'h0, 24'h0);
    xfer(8'h5e, 24'h0, 24'h0);
    chk(24'({code_a, span_a}), 24'({C3, 4'h2}), "restored");
    chk(24'(flag_n), 24'h1, "flag after restore");
    // Clear in the header of a write-and-update frame aborts it
    fork
      xfer(8'h70, cw(C1), 24'h0);
      begin
        repeat (40) @(posedge clk);
        clr_n <= 1'b0;
        repeat (6) @(posedge clk);
        clr_n <= 1'b1;
      end
    join
    chk(24'(code_a), 24'h0, "aborted frame");
    chk(24'(flag_n), 24'h0, "flag after abort");
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    ldall_n = 1'b1;
    clr_n = 1'b1;
    mspan = 1'b0;
    pins = 3'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_write_update();
    t_all_and_reserved();
    t_manual_and_load();
    t_clear();
    summarize();
  end
endmodule
